// [rtl/elc_control_bank.sv]
// E1 transmit control bank: loopbacks, channel 0 and NON_FRAME_ALIGNMENT_SIGNAL bits, data link select
//
// How it works
// - Remote loopback set: received line pair goes straight to transmit pair.
// - Backplane loopback set: every backplane input slot goes to backplane output.
// - Payload loopback set: received slots except slot zero replace transmit slots.
// - In payload loopback slot 16 loops only in CCS; else signalling byte.
// - Channel 0 flag set, backplane loopback clear: backplane slot zero carries only received NON_FRAME_ALIGNMENT_SIGNAL bytes.
// - Remote alarm bit goes out in bit three of NON_FRAME_ALIGNMENT_SIGNAL slot zero.
// - Remote alarm bit ignored while automatic remote alarm enable is zero.
// - National use bits fill NON_FRAME_ALIGNMENT_SIGNAL bits four to eight not used by link.
// - Multiframe pulse follows signalling multiframe at zero, CRC-4 at one.
// - Each set Sa select bit gives that Sa bit to the data link.
// - Sa selection only in termination mode; transparent mode forces Sa4.
// - Each clear Sa select bit takes its value from national use bits.
// - Message byte replaces each transmit slot selected for message insertion, except slot zero, slot 16 in CAS and all slots in payload loopback.
// - CCS bit picks common channel or channel associated signalling for slot 16.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module elc_control_bank
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [elc_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [elc_pkg::ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    input wire logic i_line_rx_tip,
    input wire logic i_line_rx_ring,
    input wire logic i_enc_tx_tip,
    input wire logic i_enc_tx_ring,
    output logic o_line_tx_tip,
    output logic o_line_tx_ring,
    input wire elc_pkg::elc_slot_t i_rx_slot,
    input wire elc_pkg::elc_slot_t i_backplane_data_in,
    input wire elc_pkg::elc_slot_t i_tx_slot,
    input wire logic [7:0] i_tx_signalling_byte,
    input wire logic i_tx_message_select,
    input wire logic [4:0] i_tx_datalink_bits,
    input wire logic i_rx_sig_multiframe,
    input wire logic i_rx_crc_multiframe,
    output elc_pkg::elc_slot_t o_backplane_data_out,
    output elc_pkg::elc_slot_t o_tx_line_slot,
    output logic o_rx_multiframe_pulse
);
    import elc_pkg::*;

    // ----------------------------------------------------------------
    // Registers and decode
    // ----------------------------------------------------------------
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [5:0] idx);
        reg_hit = (addr[ADDR_W-1:WORD_LSB] == idx);
    endfunction

    logic [2:0] loopback_bits;
    logic rx_channel0_non_frame_alignment_signal_only;
    logic tx_remote_alarm;
    logic [4:0] tx_national_use_bits;
    logic multiframe_output_select;
    logic [4:0] sa_datalink_select;
    logic [7:0] tx_message_byte;
    logic auto_remote_alarm_enable;
    logic tx_transparent_mode;
    logic tx_common_channel_signalling;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic do_write;
    logic [4:0] sa_effective;
    logic [1:0] rx_filt;
    logic [7:0] loop_byte;
    logic [7:0] last_non_frame_alignment_signal;
    logic [7:0] rx_mem [SLOT_COUNT];
    elc_slot_t next_tx;
    elc_slot_t next_bp;
    logic [31:0] next_rdata;
    logic next_rresp_err;

    assign do_write = !o_awready && !o_wready && !o_bvalid;

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            aw_addr <= '0;
            w_byte <= RESET_BYTE;
            w_lane0 <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_awvalid && o_awready)
            begin
                aw_addr <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready)
            begin
                w_byte <= i_wdata[7:0];
                w_lane0 <= i_wstrb[0];
                o_wready <= 1'b0;
            end
            if (do_write)
            begin
                o_bvalid <= 1'b1;
                o_bresp <= (reg_hit(aw_addr, IDX_CODING_LOOPBACK) || reg_hit(aw_addr, IDX_NFA_CONTROL)
                    || reg_hit(aw_addr, IDX_MF_DL_SELECT) || reg_hit(aw_addr, IDX_TX_MESSAGE)
                    || reg_hit(aw_addr, IDX_TX_MODE) || reg_hit(aw_addr, IDX_STATUS))
                    ? RESP_OKAY : RESP_SLVERR;
            end
            if (o_bvalid && i_bready)
            begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    // Only byte lane 0 holds register bits; other lanes are dropped
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            loopback_bits <= '0;
            rx_channel0_non_frame_alignment_signal_only <= 1'b0;
            tx_remote_alarm <= 1'b0;
            tx_national_use_bits <= '0;
            multiframe_output_select <= 1'b0;
            sa_datalink_select <= '0;
            tx_message_byte <= RESET_BYTE;
            auto_remote_alarm_enable <= 1'b0;
            tx_transparent_mode <= 1'b0;
            tx_common_channel_signalling <= 1'b0;
        end
        else if (i_ce && do_write && w_lane0)
        begin
            if (reg_hit(aw_addr, IDX_CODING_LOOPBACK))
            begin
                loopback_bits <= w_byte[CLB_REMOTE:CLB_PAYLOAD];
            end
            if (reg_hit(aw_addr, IDX_NFA_CONTROL))
            begin
                rx_channel0_non_frame_alignment_signal_only <= w_byte[NFA_CH0_ONLY];
                tx_remote_alarm <= w_byte[NFA_ALARM];
                tx_national_use_bits <= w_byte[4:0];
            end
            if (reg_hit(aw_addr, IDX_MF_DL_SELECT))
            begin
                multiframe_output_select <= w_byte[MF_SELECT];
                sa_datalink_select <= w_byte[4:0];
            end
            if (reg_hit(aw_addr, IDX_TX_MESSAGE))
            begin
                tx_message_byte <= w_byte;
            end
            if (reg_hit(aw_addr, IDX_TX_MODE))
            begin
                auto_remote_alarm_enable <= w_byte[MODE_AUTO_ALARM];
                tx_transparent_mode <= w_byte[MODE_TRANSPARENT];
                tx_common_channel_signalling <= w_byte[MODE_CCS];
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        next_rdata = '0;
        next_rresp_err = 1'b0;
        if (reg_hit(i_araddr, IDX_CODING_LOOPBACK))
            next_rdata[CLB_REMOTE:CLB_PAYLOAD] = loopback_bits;
        else if (reg_hit(i_araddr, IDX_NFA_CONTROL))
            next_rdata[7:0] = {1'b0, rx_channel0_non_frame_alignment_signal_only, tx_remote_alarm, tx_national_use_bits};
        else if (reg_hit(i_araddr, IDX_MF_DL_SELECT))
            next_rdata[7:0] = {1'b0, multiframe_output_select, 1'b0, sa_datalink_select};
        else if (reg_hit(i_araddr, IDX_TX_MESSAGE))
            next_rdata[7:0] = tx_message_byte;
        else if (reg_hit(i_araddr, IDX_TX_MODE))
        begin
            next_rdata[MODE_AUTO_ALARM] = auto_remote_alarm_enable;
            next_rdata[MODE_TRANSPARENT] = tx_transparent_mode;
            next_rdata[MODE_CCS] = tx_common_channel_signalling;
        end
        else if (reg_hit(i_araddr, IDX_STATUS))
            next_rdata[7:0] = {sa_effective, o_rx_multiframe_pulse, rx_filt};
        else
            next_rresp_err = 1'b1;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= RESP_OKAY;
        end
        else if (i_ce)
        begin
            if (i_arvalid && o_arready)
            begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= next_rdata;
                o_rresp <= next_rresp_err ? RESP_SLVERR : RESP_OKAY;
            end
            else if (o_rvalid && i_rready)
            begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Line pins: three-stage sampling, remote loopback
    // ----------------------------------------------------------------
    // Change accepted only when stages two and three agree, so a
    // metastable first stage never reaches the transmit pair
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pin
            logic s1;
            logic s2;
            logic s3;
            logic filt;
            always_ff @(posedge i_ref_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    filt <= 1'b0;
                end
                else if (i_ce)
                begin
                    s1 <= (gi == 0) ? i_line_rx_tip : i_line_rx_ring;
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3)
                        filt <= s3;
                end
            end
            // One filt flop per pin keeps each rx_filt bit to a single process
            assign rx_filt[gi] = filt;
        end
    endgenerate

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_line_tx_tip <= 1'b0;
            o_line_tx_ring <= 1'b0;
        end
        else if (i_ce)
        begin
            o_line_tx_tip <= loopback_bits[CLB_REMOTE] ? rx_filt[0] : i_enc_tx_tip;
            o_line_tx_ring <= loopback_bits[CLB_REMOTE] ? rx_filt[1] : i_enc_tx_ring;
        end
    end

    // ----------------------------------------------------------------
    // Received slot store for payload loopback
    // ----------------------------------------------------------------
    // One frame of storage absorbs the offset between receive and
    // transmit frame timing; no slip control beyond that
    always_ff @(posedge i_ref_clk)
    begin
        if (i_ce && i_rx_slot.valid)
            rx_mem[i_rx_slot.slot] <= i_rx_slot.data;
    end

    assign loop_byte = rx_mem[i_tx_slot.slot];

    // ----------------------------------------------------------------
    // Transmit slot assembly
    // ----------------------------------------------------------------
    // transparent mode forces Sa4
    assign sa_effective = tx_transparent_mode ? SA4_ONLY : sa_datalink_select;

    always_comb
    begin
        next_tx = i_tx_slot;
        if (i_tx_slot.slot == SLOT_TS0)
        begin
            if (i_tx_slot.non_frame_alignment_signal_frame)
            begin
                // alarm only with auto alarm enabled
                next_tx.data[TS0_ALARM_BIT] = auto_remote_alarm_enable & tx_remote_alarm;
                // Sa bits from link or national use
                next_tx.data[4:0] = (sa_effective & i_tx_datalink_bits) | (~sa_effective & tx_national_use_bits);
            end
        end
        else if (loopback_bits[CLB_PAYLOAD])
        begin
            // payload loopback, slot 16 only in CCS
            if (i_tx_slot.slot == SLOT_TS16 && !tx_common_channel_signalling)
                next_tx.data = i_tx_signalling_byte;
            else
                next_tx.data = loop_byte;
        end
        // CAS puts signalling in slot 16, CCS leaves HDLC byte unless message select is set
        else if (i_tx_slot.slot == SLOT_TS16 && !tx_common_channel_signalling)
            next_tx.data = i_tx_signalling_byte;
        else if (i_tx_message_select)
            next_tx.data = tx_message_byte;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_tx_line_slot <= '0;
        else if (i_ce)
            o_tx_line_slot <= next_tx;
    end

    // ----------------------------------------------------------------
    // Backplane output and multiframe pulse
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            last_non_frame_alignment_signal <= RESET_BYTE;
        else if (i_ce && i_rx_slot.valid && i_rx_slot.slot == SLOT_TS0 && i_rx_slot.non_frame_alignment_signal_frame)
            last_non_frame_alignment_signal <= i_rx_slot.data;
    end

    always_comb
    begin
        next_bp = i_rx_slot;
        if (loopback_bits[CLB_BACKPLANE])
            next_bp = i_backplane_data_in;
        // frame alignment byte replaced by last NON_FRAME_ALIGNMENT_SIGNAL byte
        else if (rx_channel0_non_frame_alignment_signal_only && i_rx_slot.slot == SLOT_TS0 && !i_rx_slot.non_frame_alignment_signal_frame)
            next_bp.data = last_non_frame_alignment_signal;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_backplane_data_out <= '0;
            o_rx_multiframe_pulse <= 1'b0;
        end
        else if (i_ce)
        begin
            o_backplane_data_out <= next_bp;
            o_rx_multiframe_pulse <= multiframe_output_select ? i_rx_crc_multiframe : i_rx_sig_multiframe;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence tx_ts0_non_frame_alignment_signal;
        i_ce && i_tx_slot.valid && i_tx_slot.non_frame_alignment_signal_frame && i_tx_slot.slot == SLOT_TS0;
    endsequence

    sequence tx_payload_slot;
        i_ce && loopback_bits[CLB_PAYLOAD] && i_tx_slot.slot != SLOT_TS0 && i_tx_slot.slot != SLOT_TS16;
    endsequence

    chk_remote_loop_path: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_ce && loopback_bits[CLB_REMOTE] && !do_write |=> o_line_tx_tip == $past(rx_filt[0])
            && o_line_tx_ring == $past(rx_filt[1]))
        else $error("remote loopback path wrong");

    chk_backplane_loop_copy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_ce && loopback_bits[CLB_BACKPLANE] |=> o_backplane_data_out == $past(i_backplane_data_in))
        else $error("backplane loopback data wrong");

    chk_payload_loop_data: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        tx_payload_slot |=> o_tx_line_slot.data == $past(loop_byte))
        else $error("payload loopback data wrong");

    chk_slot16_cas_fill: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_ce && !tx_common_channel_signalling && i_tx_slot.slot == SLOT_TS16
            |=> o_tx_line_slot.data == $past(i_tx_signalling_byte))
        else $error("slot 16 not signalling byte in CAS");

    chk_ch0_non_frame_alignment_signal_only: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_ce && !loopback_bits[CLB_BACKPLANE] && rx_channel0_non_frame_alignment_signal_only && i_rx_slot.slot == SLOT_TS0
            && !i_rx_slot.non_frame_alignment_signal_frame |=> o_backplane_data_out.data == $past(last_non_frame_alignment_signal))
        else $error("channel 0 carries frame alignment byte");

    chk_alarm_bit_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        tx_ts0_non_frame_alignment_signal ##1 !$past(auto_remote_alarm_enable) |-> !o_tx_line_slot.data[TS0_ALARM_BIT])
        else $error("alarm bit sent while auto alarm disabled");

    chk_sa_bit_merge: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        tx_ts0_non_frame_alignment_signal |=> o_tx_line_slot.data[4:0] == (($past(sa_effective) & $past(i_tx_datalink_bits))
            | (~$past(sa_effective) & $past(tx_national_use_bits))))
        else $error("Sa bit merge wrong");

    chk_transparent_sa4: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        tx_ts0_non_frame_alignment_signal ##0 tx_transparent_mode |=> o_tx_line_slot.data[4:0]
            == {$past(i_tx_datalink_bits[4]), $past(tx_national_use_bits[3:0])})
        else $error("transparent mode not forcing Sa4");

    chk_mf_pulse_source: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_ce && multiframe_output_select && !do_write |=> o_rx_multiframe_pulse == $past(i_rx_crc_multiframe))
        else $error("multiframe pulse not CRC-4 aligned");

    chk_message_insert: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_ce && i_tx_message_select && !loopback_bits[CLB_PAYLOAD] && i_tx_slot.slot != SLOT_TS0
            && i_tx_slot.slot != SLOT_TS16 |=> o_tx_line_slot.data == $past(tx_message_byte))
        else $error("message byte not inserted");

endmodule

// [rtl/elc_pkg.sv]
// Shared constants and types for the E1 loopback and NON_FRAME_ALIGNMENT_SIGNAL control bank
package elc_pkg;

    // ----------------------------------------------------------------
    // Register indexes (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [5:0] IDX_CODING_LOOPBACK = 6'h15;
    localparam logic [5:0] IDX_NFA_CONTROL = 6'h16;
    localparam logic [5:0] IDX_MF_DL_SELECT = 6'h17;
    localparam logic [5:0] IDX_TX_MESSAGE = 6'h18;
    localparam logic [5:0] IDX_TX_MODE = 6'h1A;
    localparam logic [5:0] IDX_STATUS = 6'h1B;
    localparam int ADDR_W = 8;
    localparam int WORD_LSB = 2;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CLB_REMOTE = 2;
    localparam int CLB_BACKPLANE = 1;
    localparam int CLB_PAYLOAD = 0;
    localparam int NFA_CH0_ONLY = 6;
    localparam int NFA_ALARM = 5;
    localparam int MF_SELECT = 6;
    localparam int MODE_AUTO_ALARM = 0;
    localparam int MODE_TRANSPARENT = 1;
    localparam int MODE_CCS = 5;
    localparam int STS_MF_PULSE = 2;
    localparam int STS_SA_LSB = 3;
    // Bit three of time slot zero, MSB transmitted first
    localparam int TS0_ALARM_BIT = 5;

    // ----------------------------------------------------------------
    // Reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] SA4_ONLY = 5'h10;
    localparam logic [4:0] SLOT_TS0 = 5'h00;
    localparam logic [4:0] SLOT_TS16 = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SLOT_COUNT = 32;

    // One time slot byte as it moves between framer, line and backplane
    typedef struct packed {
        logic valid;
        logic non_frame_alignment_signal_frame;
        logic [4:0] slot;
        logic [7:0] data;
    } elc_slot_t;

endpackage

// [verif/e1_loopback_non_frame_alignment_signal_dl_control_test.sv]
// Self-checking bench for the E1 loopback, NON_FRAME_ALIGNMENT_SIGNAL and data link control bank
`timescale 1ns/1ps
module e1_loopback_non_frame_alignment_signal_dl_control_test;
    import elc_pkg::*;
    localparam elc_slot_t Z = '0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [ADDR_W-1:0] awa = '0, ara = '0;
    logic [31:0] wd = '0;
    logic [3:0] ws = '0;
    logic awr, wr_rdy, bv, arr, rv, ltt, ltr, mfp;
    logic [1:0] br, rr;
    logic [31:0] rd;
    logic rtip = 1'b0, line_rx_ring = 1'b0, etip = 1'b0, ering = 1'b0, smf = 1'b0, cmf = 1'b0, msel = 1'b0;
    logic [7:0] sigb = '0;
    logic [4:0] dlb = '0;
    elc_slot_t rxs = '0, bpi = '0, txs = '0, bpo, txo;
    int errors = 0;
    int total_checks = 0;

    elc_control_bank dut (.i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_awvalid(awv), .o_awready(awr),
        .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr_rdy), .i_wdata(wd), .i_wstrb(ws), .o_bvalid(bv),
        .i_bready(bre), .o_bresp(br), .i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
        .i_rready(rre), .o_rdata(rd), .o_rresp(rr), .i_line_rx_tip(rtip), .i_line_rx_ring(line_rx_ring),
        .i_enc_tx_tip(etip), .i_enc_tx_ring(ering), .o_line_tx_tip(ltt), .o_line_tx_ring(ltr),
        .i_rx_slot(rxs), .i_backplane_data_in(bpi), .i_tx_slot(txs), .i_tx_signalling_byte(sigb),
        .i_tx_message_select(msel), .i_tx_datalink_bits(dlb), .i_rx_sig_multiframe(smf),
        .i_rx_crc_multiframe(cmf), .o_backplane_data_out(bpo), .o_tx_line_slot(txo),
        .o_rx_multiframe_pulse(mfp));

    initial
    begin
        forever #50 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Master keeps bready high from the start, so the answer is taken at once
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        awa <= {idx, 2'b00};
        wd <= {24'h000000, d};
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            n++;
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr_rdy)
                wv <= 1'b0;
            if (bv)
            begin
                done = 1'b1;
                bre <= 1'b0;
                chk("bresp", {6'h00, er}, {6'h00, br});
            end
            else if (n > 40)
            begin
                errors++;
                wrap_up();
            end
        end
    endtask

    task automatic rdc(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
        int n;
        bit done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        ara <= {idx, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        while (!done)
        begin
            @(posedge clk);
            n++;
            if (arv && arr)
                arv <= 1'b0;
            if (rv)
            begin
                done = 1'b1;
                rre <= 1'b0;
                chk("rdata", exp, rd[7:0]);
                chk("rdata high", 8'h00, rd[15:8]);
                chk("rresp", {6'h00, er}, {6'h00, rr});
            end
            else if (n > 40)
            begin
                errors++;
                wrap_up();
            end
        end
    endtask

    // Outputs are registered: look one edge after the inputs land
    task automatic dr(input elc_slot_t rx, input elc_slot_t bp, input elc_slot_t tx);
        @(posedge clk);
        rxs <= rx;
        bpi <= bp;
        txs <= tx;
        @(posedge clk);
        #1;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc(IDX_CODING_LOOPBACK, RESET_BYTE, RESP_OKAY);
        rdc(IDX_NFA_CONTROL, RESET_BYTE, RESP_OKAY);
        rdc(IDX_MF_DL_SELECT, RESET_BYTE, RESP_OKAY);
        rdc(IDX_TX_MESSAGE, RESET_BYTE, RESP_OKAY);
        rdc(IDX_TX_MODE, RESET_BYTE, RESP_OKAY);
        // Status is read-only: a write is answered but changes nothing
        wr(IDX_STATUS, 8'hFF, 4'h1, RESP_OKAY);
        rdc(IDX_STATUS, RESET_BYTE, RESP_OKAY);
        rdc(6'h10, 8'h00, RESP_SLVERR);
        wr(6'h10, 8'h55, 4'h1, RESP_SLVERR);
        wr(IDX_NFA_CONTROL, 8'h36, 4'h1, RESP_OKAY);
        wr(IDX_MF_DL_SELECT, 8'h0C, 4'h1, RESP_OKAY);
        wr(IDX_TX_MESSAGE, 8'hA5, 4'h1, RESP_OKAY);
        wr(IDX_TX_MESSAGE, 8'h00, 4'h0, RESP_OKAY);
        rdc(IDX_TX_MESSAGE, 8'hA5, RESP_OKAY);
        rdc(IDX_NFA_CONTROL, 8'h36, RESP_OKAY);
        wr(IDX_TX_MODE, 8'h01, 4'h1, RESP_OKAY);
        dlb <= 5'h0A;
        smf <= 1'b1;
        dr(Z, Z, '{1'b1, 1'b1, 5'h00, 8'hC0});
        chk("non_frame_alignment_signal alarm on", 8'hFA, txo.data);
        dr(Z, Z, '{1'b1, 1'b0, 5'h00, 8'h1B});
        chk("fas slot0", 8'h1B, txo.data);
        wr(IDX_TX_MODE, 8'h00, 4'h1, RESP_OKAY);
        dr(Z, Z, '{1'b1, 1'b1, 5'h00, 8'hC0});
        chk("non_frame_alignment_signal alarm off", 8'hDA, txo.data);
        wr(IDX_TX_MODE, 8'h02, 4'h1, RESP_OKAY);
        dr(Z, Z, '{1'b1, 1'b1, 5'h00, 8'hC0});
        chk("non_frame_alignment_signal transparent", 8'hC6, txo.data);
        wr(IDX_TX_MODE, 8'h00, 4'h1, RESP_OKAY);
        msel <= 1'b1;
        sigb <= 8'h3C;
        dr(Z, Z, '{1'b1, 1'b0, 5'h03, 8'h11});
        chk("message", 8'hA5, txo.data);
        chk("mf signalling", 8'h01, {7'h00, mfp});
        wr(IDX_CODING_LOOPBACK, 8'h01, 4'h1, RESP_OKAY);
        msel <= 1'b0;
        dr('{1'b1, 1'b0, 5'h05, 8'h77}, Z, Z);
        dr('{1'b1, 1'b0, 5'h10, 8'h66}, Z, '{1'b1, 1'b0, 5'h05, 8'h22});
        chk("payload slot5", 8'h77, txo.data);
        dr('{1'b1, 1'b0, 5'h00, 8'h99}, Z, '{1'b1, 1'b0, 5'h10, 8'h44});
        chk("payload cas ts16", 8'h3C, txo.data);
        dr(Z, Z, '{1'b1, 1'b0, 5'h00, 8'h1B});
        chk("payload ts0", 8'h1B, txo.data);
        wr(IDX_TX_MODE, 8'h20, 4'h1, RESP_OKAY);
        dr(Z, Z, '{1'b1, 1'b0, 5'h10, 8'h44});
        chk("payload ccs ts16", 8'h66, txo.data);
        wr(IDX_CODING_LOOPBACK, 8'h02, 4'h1, RESP_OKAY);
        dr('{1'b1, 1'b0, 5'h04, 8'h10}, '{1'b1, 1'b0, 5'h09, 8'hAB}, '{1'b1, 1'b0, 5'h10, 8'h44});
        chk("ccs ts16", 8'h44, txo.data);
        chk("bp loop data", 8'hAB, bpo.data);
        chk("bp loop slot", 8'h09, {3'h0, bpo.slot});
        wr(IDX_CODING_LOOPBACK, 8'h00, 4'h1, RESP_OKAY);
        wr(IDX_NFA_CONTROL, 8'h40, 4'h1, RESP_OKAY);
        dr('{1'b1, 1'b1, 5'h00, 8'h5A}, Z, Z);
        chk("bp loop off", 8'h5A, bpo.data);
        dr('{1'b1, 1'b0, 5'h00, 8'h1B}, Z, Z);
        chk("ch0 non_frame_alignment_signal only", 8'h5A, bpo.data);
        wr(IDX_NFA_CONTROL, 8'h00, 4'h1, RESP_OKAY);
        dr('{1'b1, 1'b0, 5'h00, 8'h1B}, Z, Z);
        chk("ch0 both", 8'h1B, bpo.data);
        wr(IDX_MF_DL_SELECT, 8'h40, 4'h1, RESP_OKAY);
        rtip <= 1'b1;
        ering <= 1'b1;
        wr(IDX_CODING_LOOPBACK, 8'h04, 4'h1, RESP_OKAY);
        repeat (8) @(posedge clk);
        #1;
        chk("mf crc", 8'h00, {7'h00, mfp});
        chk("remote loop", 8'h01, {6'h00, ltr, ltt});
        rdc(IDX_STATUS, 8'h01, RESP_OKAY);
        wr(IDX_CODING_LOOPBACK, 8'h00, 4'h1, RESP_OKAY);
        repeat (3) @(posedge clk);
        #1;
        chk("remote off", 8'h02, {6'h00, ltr, ltt});
        wrap_up();
    end
endmodule
